// ---- inc/dmb_cfg.svh ----
// Constants of the dual modulator bit-stream clocking block
// Assumes inclusion by the design modules and the bench
`ifndef DMB_CFG_SVH
`define DMB_CFG_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define DMB_CLK_FREQ_HZ 200000000
`define DMB_OSC_FREQ_HZ 20000000
`define DMB_OSC_CYC (`DMB_CLK_FREQ_HZ / `DMB_OSC_FREQ_HZ)
`define DMB_OSC_LAST 4'((`DMB_OSC_CYC) - 1)

// ------------------------------------------------------------
// Channel positions
// ------------------------------------------------------------
`define DMB_CH_A 0
`define DMB_CH_B 1

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define DMB_SYNC_RESET 2'h0
`define DMB_OSC_RESET 4'h0
`define DMB_BIT_RESET 1'h0
`define DMB_ACC_RESET 24'h000000

// ------------------------------------------------------------
// Loop arithmetic, 26-bit working width
// ------------------------------------------------------------
`define DMB_FB_POS 26'sh0009860
`define DMB_FB_NEG 26'sh3FF67A0
`define DMB_ACC_MAX 26'sh07FFFFF
`define DMB_ACC_MIN 26'sh3800000

`endif

// ---- inc/dmb_mod_if.sv ----
// Link between the clocking logic and one modulator channel
// Assumes dmb_pkg compiled first
`timescale 1ns/100ps
interface dmb_mod_if;
    import dmb_pkg::*;

    logic tick;
    dmb_level_t level;
    logic bit_q;

    modport source (output tick, output level, input bit_q);
    modport sink (input tick, input level, output bit_q);
endinterface

// ---- inc/dmb_pkg.sv ----
// Types of the dual modulator bit-stream clocking block
// Assumes dmb_cfg.svh on the include path
package dmb_pkg;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    localparam int DMB_NUM_CH = 2;

    typedef logic signed [15:0] dmb_level_t;
    typedef logic signed [23:0] dmb_acc_t;
    typedef logic signed [25:0] dmb_wide_t;

    typedef enum logic {
        DMB_SRC_EXT = 1'b0,
        DMB_SRC_INT = 1'b1
    } dmb_src_t;

endpackage

// ---- sim/dmb_checker.sv ----
// Port assertions for the bit-stream clocking block
// Assumes a bind to dmb_top
`timescale 1ns/100ps
module dmb_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clock_source_select,
    input wire logic external_clock_in,
    input wire logic bitstream_clock_out,
    input wire logic channel_a_bitstream,
    input wire logic channel_b_bitstream
);
    // ---
    // Sequences
    // ---
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Select pin just moved: one short phase is legal then
    logic sel_q_r;
    always_ff @(posedge clk) begin
        sel_q_r <= clock_source_select;
    end
    wire logic sel_moved_w = clock_source_select != sel_q_r;
    sequence s_int_rise;
        $rose(bitstream_clock_out) && clock_source_select && $past(clock_source_select, 24);
    endsequence
    sequence s_int_fall;
        $fell(bitstream_clock_out) && clock_source_select && $past(clock_source_select, 24);
    endsequence
    // ---
    // Properties
    // ---
    a_int_high: assert property (disable iff (!nrst || sel_moved_w)
        s_int_rise |-> bitstream_clock_out[*8] ##1 bitstream_clock_out[*2] ##1
        !bitstream_clock_out) else $error("short high phase");
    a_int_low: assert property (disable iff (!nrst || sel_moved_w)
        s_int_fall |-> !bitstream_clock_out[*8] ##1 !bitstream_clock_out[*2] ##1
        bitstream_clock_out) else $error("short low phase");
    a_int_period: assert property (disable iff (!nrst || sel_moved_w)
        s_int_rise |-> ##20 $rose(bitstream_clock_out)) else $error("bit clock period wrong");
    a_ext_follow: assert property ($rose(external_clock_in) && !clock_source_select
        && !$past(clock_source_select, 4) |-> ##[2:5] $changed(bitstream_clock_out))
        else $error("bit clock missed source edge");
    a_ext_hold: assert property ((!clock_source_select && $stable(external_clock_in))[*5]
        |=> $stable(bitstream_clock_out)) else $error("bit clock moved without edge");
    a_toggle_space: assert property (disable iff (!nrst || sel_moved_w)
        $changed(bitstream_clock_out) && clock_source_select == $past(clock_source_select, 6)
        |=> $stable(bitstream_clock_out)[*6]) else $error("bit clock toggled too soon");
    a_bit_launch: assert property ($changed(channel_a_bitstream) ||
        $changed(channel_b_bitstream) |-> $past(bitstream_clock_out, 1)
        && !$past(bitstream_clock_out, 2)) else $error("stream bit off launch edge");
    a_reset_quiet: assert property ($rose(nrst) |-> !bitstream_clock_out
        && !channel_a_bitstream && !channel_b_bitstream) else $error("output high at reset");
endmodule

// ---- sim/dmb_filter_model.sv ----
// Receiving filter model: counts ones of both streams
// Assumes the bit clock and streams of dmb_top
`timescale 1ns/100ps
module dmb_filter_model (
    input wire logic clr,
    input wire logic bitstream_clock_out,
    input wire logic channel_a_bitstream,
    input wire logic channel_b_bitstream,
    output int ones_a,
    output int ones_b,
    output int bits
);
    // ---
    // Capture on falling edge, accumulate
    // ---
    always @(negedge bitstream_clock_out or posedge clr) begin
        if (clr) begin
            ones_a <= 0;
            ones_b <= 0;
            bits <= 0;
        end else begin
            ones_a <= ones_a + int'(channel_a_bitstream);
            ones_b <= ones_b + int'(channel_b_bitstream);
            bits <= bits + 1;
        end
    end
endmodule

// ---- sim/dmb_top_tb_top.sv ----
// Bench for dmb_top: clock modes, bit clock period, stream density
// Assumes design, filter model and checker compiled first
`timescale 1ns/100ps
`include "dmb_cfg.svh"
module dmb_top_tb_top;
    logic clk = 0, nrst = 0, sel = 1, ext = 0, clr = 0, bco, out_a, out_b;
    dmb_pkg::dmb_level_t lvl_a = 16'h0000, lvl_b = 16'h0000;
    int ones_a, ones_b, bits, h = 6, hv, ecnt = 0, fail_count = 0, check_count = 0, n;
    logic [31:0] seed = 32'hBA317DFC, r;

    dmb_top i_dut (.clk(clk), .nrst(nrst), .clock_source_select(sel), .external_clock_in(ext),
        .channel_a_level(lvl_a), .channel_b_level(lvl_b), .bitstream_clock_out(bco),
        .channel_a_bitstream(out_a), .channel_b_bitstream(out_b));
    dmb_filter_model i_rx (.clr(clr), .bitstream_clock_out(bco), .channel_a_bitstream(out_a),
        .channel_b_bitstream(out_b), .ones_a(ones_a), .ones_b(ones_b), .bits(bits));

    // ---
    // Clock and external source
    // ---
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        ecnt <= (ecnt >= h - 1) ? 0 : ecnt + 1;
        if (ecnt >= h - 1) ext <= ~ext;
    end

    // ---
    // Helpers
    // ---
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int exp_ones(input int l);
        return 256 + (21504 * l) / 3276700;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic next_rise(output int k);
        logic p;
        k = 0;
        p = bco;
        repeat (1000) begin
            @(posedge clk);
            #1;
            k++;
            if (!p && bco) return;
            p = bco;
        end
        fail_count++;
        stop_test();
    endtask
    task automatic density(input int la, input int lb);
        @(posedge clk);
        lvl_a <= 16'(la);
        lvl_b <= 16'(lb);
        repeat (3) next_rise(n);
        clr = 1;
        @(posedge clk);
        clr = 0;
        repeat (512) next_rise(n);
        check(32'(ones_a > exp_ones(la) - 16 && ones_a < exp_ones(la) + 16), 32'h1);
        check(32'(ones_b > exp_ones(lb) - 16 && ones_b < exp_ones(lb) + 16), 32'h1);
        check(32'(bits), 32'h200);
    endtask

    // ---
    // Main sequence
    // ---
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1;
        next_rise(n);
        next_rise(n);
        check(32'(n), 32'(2 * `DMB_OSC_CYC));
        density(0, 32767);
        r = xs();
        density(-32768, int'($signed(r[15:0])));
        @(posedge clk);
        sel <= 0;
        repeat (3) begin
            r = xs();
            hv = 5 + int'(r[3:0]);
            @(posedge clk);
            h <= hv;
            repeat (3) next_rise(n);
            check(32'(n), 32'(4 * hv));
        end
        stop_test();
    end
endmodule

bind dmb_top dmb_checker i_chk (.clk, .nrst, .clock_source_select, .external_clock_in,
    .bitstream_clock_out, .channel_a_bitstream, .channel_b_bitstream);

// ---- src/dmb_mod.sv ----
// One second-order delta-sigma modulator channel
// Assumes a one-cycle tick per modulator clock period on clk
`timescale 1ns/100ps
`include "dmb_cfg.svh"
module dmb_mod
    import dmb_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    dmb_mod_if.sink port
);

    // ------------------------------------------------------------
    // Loop state
    // ------------------------------------------------------------
    dmb_acc_t int1_r;
    dmb_acc_t int2_r;
    logic dac_r;

    function automatic dmb_acc_t dmb_sat(input dmb_wide_t v);
        dmb_acc_t res;
        if (v > `DMB_ACC_MAX) begin
            res = 24'(`DMB_ACC_MAX);
        end else if (v < `DMB_ACC_MIN) begin
            res = 24'(`DMB_ACC_MIN);
        end else begin
            res = v[23:0];
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Integrators and comparator
    // ------------------------------------------------------------
    wire dmb_wide_t fb_w = dac_r ? `DMB_FB_POS : `DMB_FB_NEG;
    wire dmb_wide_t level_w = {{10{port.level[15]}}, port.level};
    wire dmb_wide_t int1_w = {{2{int1_r[23]}}, int1_r};
    wire dmb_wide_t int2_w = {{2{int2_r[23]}}, int2_r};
    wire dmb_wide_t err1_w = (level_w - fb_w) >>> 1;
    wire dmb_wide_t err2_w = (int1_w - fb_w) >>> 1;
    wire dmb_acc_t int1_nxt = dmb_sat(int1_w + err1_w);
    wire dmb_acc_t int2_nxt = dmb_sat(int2_w + err2_w);
    // Comparator decides on the value the second integrator is taking;
    // deciding on the old value adds a loop delay that makes it unstable
    wire logic cmp_w = ~int2_nxt[23];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            int1_r <= `DMB_ACC_RESET;
            int2_r <= `DMB_ACC_RESET;
        end else if (port.tick) begin
            int1_r <= int1_nxt;
            int2_r <= int2_nxt;
        end
    end

    // Feedback takes the comparator on the same tick the integrators update
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dac_r <= `DMB_BIT_RESET;
        end else if (port.tick) begin
            dac_r <= cmp_w;
        end
    end

    assign port.bit_q = dac_r;

endmodule

// ---- src/dmb_top.sv ----
// Digital side of a two-channel delta-sigma modulator with clocking
// Assumes clk at 200 MHz; source select and external clock are async pins
//
// Behaviour
// - With the select pin high both modulators run from the fixed 20 MHz internal oscillator.
// - With the select pin low both modulators run from the external clock pin.
// - The selected clock is halved to form the shared modulator clock of both channels.
// - Each channel emits a one-bit stream whose density of ones tracks its input level.
// - Each stream goes only to its own channel pin, both channels converting together.
// - A new bit is launched on each channel just after each rising bit clock edge.
// - The feedback converter takes the comparator on the same modulator clock the integrators update.
// - The modulator clock is driven out on a dedicated bit clock pin.
// - Density of ones is 50% at zero input, 92% at the top limit and 8% at the bottom.
`timescale 1ns/100ps
`include "dmb_cfg.svh"
module dmb_top
    import dmb_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic clock_source_select,
    input wire logic external_clock_in,
    input wire dmb_level_t channel_a_level,
    input wire dmb_level_t channel_b_level,
    output logic bitstream_clock_out,
    output logic channel_a_bitstream,
    output logic channel_b_bitstream
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sel_sync_r;
    logic [1:0] ext_sync_r;
    logic ext_prev_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_sync_r <= `DMB_SYNC_RESET;
            ext_sync_r <= `DMB_SYNC_RESET;
        end else begin
            sel_sync_r <= {sel_sync_r[0], clock_source_select};
            ext_sync_r <= {ext_sync_r[0], external_clock_in};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_prev_r <= `DMB_BIT_RESET;
        end else begin
            ext_prev_r <= ext_sync_r[1];
        end
    end

    wire logic ext_rise_w = ext_sync_r[1] & ~ext_prev_r;

    // ------------------------------------------------------------
    // Internal 20 MHz oscillator
    // ------------------------------------------------------------
    logic [3:0] osc_cnt_r;

    wire logic osc_rise_w = (osc_cnt_r == `DMB_OSC_LAST);
    wire logic [3:0] osc_cnt_nxt = osc_rise_w ? `DMB_OSC_RESET : osc_cnt_r + 4'h1;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            osc_cnt_r <= `DMB_OSC_RESET;
        end else begin
            osc_cnt_r <= osc_cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------
    wire dmb_src_t src_sel_w = dmb_src_t'(sel_sync_r[1]);
    wire logic src_rise_w = (src_sel_w == DMB_SRC_INT) ? osc_rise_w : ext_rise_w;

    // ------------------------------------------------------------
    // Divide by two and bit clock pin
    // ------------------------------------------------------------
    logic div_r;
    logic launch_r;

    wire logic div_nxt = src_rise_w ? ~div_r : div_r;
    wire logic div_up_w = src_rise_w & ~div_r;

    // No gating besides power-up reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_r <= `DMB_BIT_RESET;
        end else begin
            div_r <= div_nxt;
        end
    end

    // Tick lands in the same cycle the bit clock goes high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            launch_r <= `DMB_BIT_RESET;
        end else begin
            launch_r <= div_up_w;
        end
    end

    assign bitstream_clock_out = div_r;

    // ------------------------------------------------------------
    // Modulator channels
    // ------------------------------------------------------------
    dmb_level_t level_w [DMB_NUM_CH];
    logic bits_w [DMB_NUM_CH];

    assign level_w[`DMB_CH_A] = channel_a_level;
    assign level_w[`DMB_CH_B] = channel_b_level;

    genvar g;
    generate
        for (g = 0; g < DMB_NUM_CH; g++) begin : g_ch
            dmb_mod_if u_if ();
            assign u_if.tick = launch_r;
            assign u_if.level = level_w[g];
            dmb_mod u_mod (
                .clk(clk),
                .nrst(nrst),
                .port(u_if.sink)
            );
            assign bits_w[g] = u_if.bit_q;
        end
    endgenerate

    // Each pin fed by its own modulator flop
    assign channel_a_bitstream = bits_w[`DMB_CH_A];
    assign channel_b_bitstream = bits_w[`DMB_CH_B];

endmodule
